/* hdl/vfb_pkg.sv */
// Constants and carrier types for the video field buffer
package vfb_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int VFB_DATA_W     = 8;
    localparam int VFB_ROWS       = 4096;
    localparam int VFB_ROW_W      = 12;
    localparam int VFB_IDX_W      = 6;
    localparam int VFB_SA_W       = 7;
    localparam int VFB_SRAM_WORDS = 80;
    localparam int VFB_REG_BITS   = 64 * VFB_DATA_W;
    localparam logic [6:0]  VFB_SRAM_LAST = 7'h4f;
    localparam logic [5:0]  VFB_IDX_LAST  = 6'h3f;
    localparam logic [11:0] VFB_ROW_LAST  = 12'hfff;
    localparam int VFB_FIFO_DEPTH = 16;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int VFB_CLK_MHZ = 100;
    localparam int VFB_REF_NS  = 15600;
    localparam int VFB_REF_CYC = (VFB_REF_NS * VFB_CLK_MHZ) / 1000;
    localparam int VFB_REF_W   = 11;
    localparam logic [10:0] VFB_REF_LAST = VFB_REF_W'(VFB_REF_CYC - 1);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        GNT_IDLE    = 2'b00,
        GNT_LOAD    = 2'b01,
        GNT_WRITE   = 2'b10,
        GNT_REFRESH = 2'b11
    } vfb_grant_e;

    typedef struct packed {
        logic       write_clock;
        logic       we_n;
        logic       wclr_n;
        logic [7:0] wdata;
        logic       rd_clock;
        logic       re_n;
        logic       oe_n;
        logic       rclr_n;
    } vfb_pins_s;

    typedef struct packed {
        logic       restart;
        logic       sram;
        logic [6:0] sa;
        logic [5:0] idx;
        logic [7:0] data;
    } vfb_wr_word_s;

endpackage : vfb_pkg

/* hdl/vfb_field_buffer.sv */
// Video field buffer: write staging FIFO and field memory top level
//
// Summary of operation
// - Enabled write cycle stores a word, pointer advances
// - Write disabled: no store, pointer frozen
// - Controls sampled at the edge opening a cycle
// - Write data captured at the cycle's closing edge
// - Read enabled: one word out per cycle
// - Read disabled: read pointer frozen
// - Output off tristates data, pointer unaffected
// - Full write register goes to array as row
// - Emptied read register reloads next array row
// - First 80 words after reset use SRAM
// - Write row counter steps, wraps after last
// - Read row counter steps, clears on reset
// - Timer driven refresh; selector picks row address
// - Reset accepted anytime; deferred past disabled cycles
// - Reset cycle itself is address zero
// - Crossing addresses may give old last words
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Staging FIFO
// ----------------------------------------------------------------
module vfb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    import vfb_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          rdy;
        logic          vld;
    } vfb_fifo_s;

    vfb_fifo_s        st;
    vfb_fifo_s        next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    always_comb begin
        next_st = st;
        push = in_valid_in && st.rdy;
        pop = st.vld && out_ready_in;
        if (push) begin
            next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        next_st.rdy = (next_st.cnt != FULL);
        next_st.vld = (next_st.cnt != '0);
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[st.wp] <= in_data_in;
        end
    end

    assign in_ready_out  = st.rdy;
    assign out_valid_out = st.vld;
    assign out_data_out  = mem[st.rp];

endmodule : vfb_fifo

// ----------------------------------------------------------------
// Field buffer top
// ----------------------------------------------------------------
module vfb_field_buffer (
    // System clock and reset
    input  wire logic       clock_in,
    input  wire logic       arst_n_in,
    // Write port pins
    input  wire logic       write_clock_in,
    input  wire logic       write_enable_n_in,
    input  wire logic       wr_ptr_clear_n_in,
    input  wire logic [7:0] write_data_in,
    // Read port pins
    input  wire logic       rd_clock_in,
    input  wire logic       rd_advance_n_in,
    input  wire logic       out_drive_n_in,
    input  wire logic       rd_ptr_clear_n_in,
    input  wire logic       test_in,
    // Read data, three-state
    output logic [7:0]      read_data_out,
    output logic            read_data_oe_out,
    // Staging status
    output logic            wr_fifo_ready_out,
    output logic            wr_overrun_out
);
    import vfb_pkg::*;

    typedef struct packed {
        vfb_pins_s         s1;
        vfb_pins_s         s2;
        logic              wck_q;
        logic              rck_q;
        logic              w_open;
        vfb_wr_word_s      w_ent;
        logic              w_clr_pend;
        logic              w_sram;
        logic [6:0]        w_sa;
        logic [5:0]        w_idx;
        logic              push_v;
        vfb_wr_word_s      push_d;
        logic              overrun;
        logic [11:0]       d_row;
        logic [511:0]      wreg;
        logic              r_clr_pend;
        logic              r_sram;
        logic [6:0]        r_sa;
        logic [5:0]        r_idx;
        logic [11:0]       r_row;
        logic              ld_pend;
        logic [11:0]       ld_row;
        logic              ld_fill;
        logic [511:0]      rreg;
        logic [7:0]        dout;
        logic              oe;
        logic [10:0]       ref_cnt;
        logic              ref_pend;
        logic [11:0]       ref_row;
    } vfb_top_s;

    vfb_top_s     st;
    vfb_top_s     next_st;
    logic [1:0]   rst_sync;
    logic         rst_n;
    vfb_pins_s    pins;
    vfb_wr_word_s drain;
    logic         drain_vld;
    logic         drain_rdy;
    logic         fifo_rdy;
    logic         pop;
    vfb_grant_e   gnt;
    logic [11:0]  arr_row;
    logic         arr_we;
    logic [511:0] arr_wd;
    logic [511:0] rd_q;
    logic         sram_we;
    logic         w_edge;
    logic         r_edge;
    logic         clr;
    logic         p_sram;
    logic [6:0]   p_sa;
    logic [5:0]   p_idx;

    logic [511:0] mem  [VFB_ROWS];
    logic [7:0]   sram [VFB_SRAM_WORDS];

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign pins = '{write_clock: write_clock_in, we_n: write_enable_n_in,
                    wclr_n: wr_ptr_clear_n_in, wdata: write_data_in,
                    rd_clock: rd_clock_in, re_n: rd_advance_n_in,
                    oe_n: out_drive_n_in, rclr_n: rd_ptr_clear_n_in};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.wck_q = st.s2.write_clock;
        next_st.rck_q = st.s2.rd_clock;
        next_st.push_v = 1'b0;
        next_st.ld_fill = 1'b0;
        // Both pin clocks pass two sampling stages, so each edge is seen two clocks after its pin rises
        w_edge = st.s2.write_clock && !st.wck_q;
        r_edge = st.s2.rd_clock && !st.rck_q;
        pop = drain_vld && drain_rdy;
        gnt = GNT_IDLE;
        arr_row = '0;
        arr_we = 1'b0;
        sram_we = 1'b0;
        clr = 1'b0;
        p_sram = st.r_sram;
        p_sa = st.r_sa;
        p_idx = st.r_idx;

        // Write port: close the open cycle, then open the next
        if (w_edge) begin
            if (st.w_open) begin
                next_st.push_v = 1'b1;
                next_st.push_d = st.w_ent;
                next_st.push_d.data = st.s2.wdata;
            end
            clr = !st.s2.wclr_n || st.w_clr_pend;
            if (st.s2.we_n) begin
                next_st.w_open = 1'b0;
                if (!st.s2.wclr_n) begin
                    next_st.w_clr_pend = 1'b1;
                end
            end else begin
                next_st.w_open = 1'b1;
                next_st.w_clr_pend = 1'b0;
                next_st.w_ent = '{restart: clr, sram: st.w_sram | clr,
                                  sa: clr ? 7'h00 : st.w_sa,
                                  idx: st.w_idx, data: 8'h00};
                if (clr) begin
                    next_st.w_sram = 1'b1;
                    next_st.w_sa = 7'h01;
                end else if (st.w_sram) begin
                    if (st.w_sa == VFB_SRAM_LAST) begin
                        next_st.w_sram = 1'b0;
                        next_st.w_idx = 6'h00;
                    end else begin
                        next_st.w_sa = st.w_sa + 7'h01;
                    end
                end else begin
                    next_st.w_idx = st.w_idx + 6'h01;
                end
            end
        end

        // A dropped word is remembered until reset
        if (st.push_v && !fifo_rdy) begin
            next_st.overrun = 1'b1;
        end

        // Drain staging words into SRAM or the write register
        if (pop) begin
            if (drain.restart) begin
                next_st.d_row = 12'h000;
                next_st.wreg = '0;
            end
            if (drain.sram) begin
                sram_we = 1'b1;
            end else begin
                next_st.wreg[{drain.idx, 3'h0} +: 8] = drain.data;
                if (drain.idx == VFB_IDX_LAST) begin
                    gnt = GNT_WRITE;
                    next_st.d_row = (st.d_row == VFB_ROW_LAST) ?
                                    12'h000 : st.d_row + 12'h001;
                end
            end
        end
        arr_wd = next_st.wreg;

        // Row selector; a waiting load holds the drain off instead
        if (st.ld_pend) begin
            gnt = GNT_LOAD;
        end else if (gnt == GNT_IDLE && st.ref_pend) begin
            gnt = GNT_REFRESH;
        end
        case (gnt)
            GNT_LOAD: begin
                arr_row = st.ld_row;
                next_st.ld_pend = 1'b0;
                next_st.ld_fill = 1'b1;
                next_st.r_row = st.ld_row;
            end
            GNT_WRITE: begin
                arr_row = st.d_row;
                arr_we = 1'b1;
            end
            GNT_REFRESH: begin
                arr_row = st.ref_row;
                next_st.ref_pend = 1'b0;
                next_st.ref_row = st.ref_row + 12'h001;
            end
            default: begin
                arr_row = st.ref_row;
            end
        endcase
        if (st.ld_fill) begin
            next_st.rreg = rd_q;
        end

        // Refresh timer; its request waits while a same-cycle load or write holds the grant
        if (st.ref_cnt == VFB_REF_LAST) begin
            next_st.ref_cnt = 11'h000;
            next_st.ref_pend = 1'b1;
        end else begin
            next_st.ref_cnt = st.ref_cnt + 11'h001;
        end

        // Read port: controls taken at the opening edge
        if (r_edge) begin
            next_st.oe = !st.s2.oe_n;
            clr = !st.s2.rclr_n || st.r_clr_pend;
            if (st.s2.re_n) begin
                if (!st.s2.rclr_n) begin
                    next_st.r_clr_pend = 1'b1;
                end
            end else if (clr) begin
                p_sram = 1'b1;
                p_sa = 7'h00;
                next_st.r_clr_pend = 1'b0;
                next_st.ld_pend = 1'b1;
                next_st.ld_row = 12'h000;
            end
            // Frozen cycle repeats the word already shown
            if (!st.s2.re_n) begin
                next_st.dout = p_sram ? sram[p_sa] :
                               st.rreg[{p_idx, 3'h0} +: 8];
            end
            next_st.r_sram = p_sram;
            next_st.r_sa = p_sa;
            next_st.r_idx = p_idx;
            if (!st.s2.re_n) begin
                if (p_sram) begin
                    if (p_sa == VFB_SRAM_LAST) begin
                        next_st.r_sram = 1'b0;
                        next_st.r_idx = 6'h00;
                    end else begin
                        next_st.r_sa = p_sa + 7'h01;
                    end
                end else begin
                    next_st.r_idx = p_idx + 6'h01;
                    if (p_idx == VFB_IDX_LAST) begin
                        next_st.ld_pend = 1'b1;
                        next_st.ld_row = (st.r_row == VFB_ROW_LAST) ?
                                         12'h000 : st.r_row + 12'h001;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Array, SRAM and staging
    // ----------------------------------------------------------------
    // Whole-row access keeps a block transfer to one array cycle
    always_ff @(posedge clock_in) begin
        if (arr_we) begin
            mem[arr_row] <= arr_wd;
        end
        rd_q <= mem[arr_row];
    end

    always_ff @(posedge clock_in) begin
        if (sram_we) begin
            sram[drain.sa] <= drain.data;
        end
    end

    assign drain_rdy = !st.ld_pend;

    vfb_fifo #(
        .WIDTH ($bits(vfb_wr_word_s)),
        .DEPTH (VFB_FIFO_DEPTH)
    ) u_stage (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n),
        .in_valid_in   (st.push_v),
        .in_ready_out  (fifo_rdy),
        .in_data_in    (st.push_d),
        .out_valid_out (drain_vld),
        .out_ready_in  (drain_rdy),
        .out_data_out  (drain)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign read_data_out     = st.dout;
    assign read_data_oe_out  = st.oe;
    assign wr_fifo_ready_out = fifo_rdy;
    assign wr_overrun_out    = st.overrun;

endmodule : vfb_field_buffer

`default_nettype wire

/* sim/vfb_field_buffer_props.sv */
// Port-level checks for the video field buffer
`timescale 1ns/1ns
`default_nettype none

module vfb_field_buffer_props (
    // Clock and reset
    input wire logic       clock_in,
    input wire logic       arst_n_in,
    // Read port pins
    input wire logic       rd_clock_in,
    input wire logic       rd_advance_n_in,
    input wire logic       out_drive_n_in,
    // Outputs watched
    input wire logic [7:0] read_data_out,
    input wire logic       read_data_oe_out,
    input wire logic       wr_fifo_ready_out,
    input wire logic       wr_overrun_out
);
    logic [3:0] since_rd;
    logic       rd_prev;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    // ----------------------------------------------------------------
    // Cycles since the read pin last rose, saturating
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            since_rd <= 4'hf;
            rd_prev  <= 1'b0;
        end else begin
            rd_prev <= rd_clock_in;
            if (rd_clock_in && !rd_prev) begin
                since_rd <= 4'h0;
            end else if (since_rd != 4'hf) begin
                since_rd <= since_rd + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_reset_values: assert property ($rose(arst_n_in) |-> read_data_out == 8'h00 &&
        !read_data_oe_out && !wr_overrun_out) else $error("outputs not at reset values");
    a_reset_ready: assert property ($rose(arst_n_in) |-> wr_fifo_ready_out [*2])
        else $error("staging not ready after reset");
    a_oe_off_time: assert property ($rose(rd_clock_in) && out_drive_n_in |->
        ##[2:6] !read_data_oe_out) else $error("output not released when drive off");
    a_oe_on_time: assert property ($rose(rd_clock_in) && !out_drive_n_in |->
        ##[2:6] read_data_oe_out) else $error("output not driven when drive on");
    a_oe_hold: assert property ($changed(read_data_oe_out) |-> since_rd inside {[1:6]})
        else $error("output enable moved without a read edge");
    a_rdata_hold: assert property ($changed(read_data_out) |-> since_rd inside {[1:6]})
        else $error("read data moved without a read edge");
    a_no_overrun: assert property (wr_fifo_ready_out |=> !$rose(wr_overrun_out))
        else $error("overrun flagged while staging had room");
    a_frozen_hold: assert property ($rose(rd_clock_in) && rd_advance_n_in && !out_drive_n_in
        && read_data_oe_out |-> ##6 read_data_out == $past(read_data_out, 6))
        else $error("frozen read cycle changed the word");

    c_oe_rise: cover property ($rose(read_data_oe_out));
    c_oe_fall: cover property ($fell(read_data_oe_out));
    c_frozen: cover property ($rose(rd_clock_in) && rd_advance_n_in);

endmodule : vfb_field_buffer_props

bind vfb_field_buffer vfb_field_buffer_props u_vfb_field_buffer_props (
    .clock_in         (clock_in),
    .arst_n_in        (arst_n_in),
    .rd_clock_in      (rd_clock_in),
    .rd_advance_n_in  (rd_advance_n_in),
    .out_drive_n_in   (out_drive_n_in),
    .read_data_out    (read_data_out),
    .read_data_oe_out (read_data_oe_out),
    .wr_fifo_ready_out(wr_fifo_ready_out),
    .wr_overrun_out   (wr_overrun_out)
);

`default_nettype wire

/* sim/vfb_host.sv */
// Host-side pin driver for the video field buffer
`timescale 1ns/1ns
`default_nettype none

module vfb_host
    import vfb_pkg::*;
(
    // System clock
    input  wire logic              clock_in,
    // Pins toward the buffer
    output var vfb_pkg::vfb_pins_s pins_out
);
    // Pin clocks idle low so no false edge at reset release
    initial pins_out = '{1'b0, 1'b1, 1'b1, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};

    // ----------------------------------------------------------------
    // Write cycle: period 4 clocks, data closes the previous cycle
    // ----------------------------------------------------------------
    task automatic wr_cycle(input logic we_n, input logic clr_n, input logic [7:0] data);
        @(posedge clock_in);
        #1;
        pins_out.we_n   = we_n;
        pins_out.wclr_n = clr_n;
        pins_out.wdata  = data;
        @(posedge clock_in);
        #1;
        pins_out.write_clock = 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        pins_out.write_clock = 1'b0;
    endtask : wr_cycle

    // ----------------------------------------------------------------
    // Read cycle: period 7 clocks, returns once the word has settled
    // ----------------------------------------------------------------
    task automatic rd_cycle(input logic re_n, input logic oe_n, input logic clr_n);
        @(posedge clock_in);
        #1;
        pins_out.re_n   = re_n;
        pins_out.oe_n   = oe_n;
        pins_out.rclr_n = clr_n;
        @(posedge clock_in);
        #1;
        pins_out.rd_clock = 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        pins_out.rd_clock = 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
    endtask : rd_cycle

endmodule : vfb_host

`default_nettype wire

/* sim/vfb_field_buffer_tb.sv */
// Self-checking bench for the video field buffer
`timescale 1ns/1ns
`default_nettype none

module vfb_field_buffer_tb;
    import vfb_pkg::*;

    localparam int LIMIT = 40000;

    logic       clock_in;
    logic       arst_n_in;
    logic       test_in;
    vfb_pins_s  pins;
    logic [7:0] read_data_out;
    logic       read_data_oe_out;
    logic       wr_fifo_ready_out;
    logic       wr_overrun_out;
    int         err_total;
    int         cmp_count;
    int         cycles;
    logic [7:0] exp_q[$];

    vfb_host u_vfb_host (.clock_in(clock_in), .pins_out(pins));

    vfb_field_buffer u_vfb_field_buffer (
        .clock_in(clock_in), .arst_n_in(arst_n_in),
        .write_clock_in(pins.write_clock), .write_enable_n_in(pins.we_n),
        .wr_ptr_clear_n_in(pins.wclr_n), .write_data_in(pins.wdata),
        .rd_clock_in(pins.rd_clock), .rd_advance_n_in(pins.re_n),
        .out_drive_n_in(pins.oe_n), .rd_ptr_clear_n_in(pins.rclr_n),
        .test_in(test_in), .read_data_out(read_data_out),
        .read_data_oe_out(read_data_oe_out), .wr_fifo_ready_out(wr_fifo_ready_out),
        .wr_overrun_out(wr_overrun_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // ----------------------------------------------------------------
    // Field write with a disabled cycle every ninth; junk on dead data
    // ----------------------------------------------------------------
    task automatic wr_field(input logic [7:0] base, input int n, input bit deferred);
        logic [7:0] prev;
        bit         prev_en;
        bit         en;
        prev = 8'h5a;
        prev_en = 1'b0;
        exp_q.delete();
        if (deferred) u_vfb_host.wr_cycle(1'b1, 1'b0, ~prev);
        for (int i = 0; i < n; i++) begin
            en = (i % 9 != 5);
            u_vfb_host.wr_cycle(!en, (i == 0 && !deferred) ? 1'b0 : 1'b1,
                                prev_en ? prev : ~prev);
            if (en) begin
                prev = base + 8'(i * 5);
                exp_q.push_back(prev);
            end
            prev_en = en;
        end
        u_vfb_host.wr_cycle(1'b1, 1'b1, prev);
        repeat (40) @(posedge clock_in);
    endtask : wr_field

    // ----------------------------------------------------------------
    // Field read from a clear, with frozen and undriven cycles mixed in
    // ----------------------------------------------------------------
    task automatic rd_field(input int n);
        int         k;
        int         i;
        logic [7:0] last;
        k = 0;
        i = 0;
        last = 8'h00;
        while (k < n) begin
            if (i % 11 == 7 && i % 13 != 10) begin
                u_vfb_host.rd_cycle(1'b1, 1'b0, 1'b1);
                check(read_data_out, last);
            end else if (i % 13 == 9) begin
                u_vfb_host.rd_cycle(1'b0, 1'b1, 1'b1);
                check({7'h00, read_data_oe_out}, 8'h00);
                last = exp_q[k];
                k++;
            end else begin
                u_vfb_host.rd_cycle(1'b0, 1'b0, (i == 0) ? 1'b0 : 1'b1);
                check(read_data_out, exp_q[k]);
                check({7'h00, read_data_oe_out}, 8'h01);
                last = exp_q[k];
                k++;
            end
            i++;
        end
    endtask : rd_field

    // Idle wait, both clears, then more than 82 dummy cycles
    task automatic scen_power_up();
        repeat (10000) @(posedge clock_in);
        fork
            begin
                u_vfb_host.wr_cycle(1'b0, 1'b0, 8'h00);
                repeat (83) u_vfb_host.wr_cycle(1'b0, 1'b1, 8'h00);
            end
            begin
                u_vfb_host.rd_cycle(1'b0, 1'b0, 1'b0);
                repeat (83) u_vfb_host.rd_cycle(1'b0, 1'b0, 1'b1);
            end
        join
    endtask : scen_power_up

    // Whole field written ahead of reading, past SRAM into array rows
    task automatic scen_stream();
        wr_field(8'h11, 380, 1'b0);
        rd_field(336);
    endtask : scen_stream

    // Write clear given in a disabled cycle lands on the next one
    task automatic scen_deferred();
        wr_field(8'h80, 170, 1'b1);
        rd_field(144);
    endtask : scen_deferred

    // Old field read back while the same addresses are rewritten
    task automatic scen_old();
        fork
            for (int i = 0; i < 24; i++) begin
                u_vfb_host.wr_cycle(1'b0, (i == 0) ? 1'b0 : 1'b1, 8'(i));
                repeat (3) @(posedge clock_in);
            end
            for (int j = 0; j < 24; j++) begin
                u_vfb_host.rd_cycle(1'b0, 1'b0, (j == 0) ? 1'b0 : 1'b1);
                check(read_data_out, exp_q[j]);
            end
        join
    endtask : scen_old

    // Staging seen through the top: a fast write burst never backs up
    task automatic scen_fifo();
        repeat (24) begin
            u_vfb_host.wr_cycle(1'b0, 1'b1, 8'h3c);
            check({7'h00, wr_fifo_ready_out}, 8'h01);
            check({7'h00, wr_overrun_out}, 8'h00);
        end
        repeat (20) @(posedge clock_in);
        check({7'h00, wr_fifo_ready_out}, 8'h01);
        check({7'h00, wr_overrun_out}, 8'h00);
    endtask : scen_fifo

    initial begin
        arst_n_in = 1'b0;
        test_in = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (5) @(posedge clock_in);
        #1;
        arst_n_in = 1'b1;
        check({6'h00, read_data_oe_out, wr_overrun_out}, 8'h00);
        check({7'h00, wr_fifo_ready_out}, 8'h01);
        scen_power_up();
        scen_stream();
        scen_deferred();
        scen_old();
        scen_fifo();
        check({7'h00, wr_overrun_out}, 8'h00);
        summarize();
    end

endmodule : vfb_field_buffer_tb

`default_nettype wire
